// *** verification/tb_rflpc_regs.sv ***
/* Self-checking bench of the reset, FIFO level and power control registers.
   Assumes the package, the header and rflpc_regs are compiled before it. */
`timescale 1ns/1ps
`define CHK(n,e,s) begin check_count++; if ((s)!==(e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_rflpc_regs;
  import rflpc_pkg::*;
  logic sys_clk=0, reset_n=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0;
  logic s_axi_arvalid=0, s_axi_rready=0, phy_select_pin=1, phy_clk_present_pin=0;
  logic eeprom_load_done=0, rx_frame_store=0, rx_drain=0, tx_alloc=0, tx_release=0;
  logic resume_done=0, resume_remote=0, dev_normal_state=1, hw_config_done=1;
  logic lite_reset_start=0, config_entered=0, deconfigured=0;
  logic [11:0] s_axi_awaddr=0, s_axi_araddr=0;
  logic [31:0] s_axi_wdata=0, s_axi_rdata;
  logic [3:0] s_axi_wstrb=4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, s;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  rflpc_level_t rx_frame_len=0, rx_drain_bytes=16'h4, tx_alloc_bytes=0, tx_release_bytes=16'h8;
  logic device_soft_reset, ext_phy_reset, usb_phy_disconnect, eeprom_reload_req;
  logic clr_wake_status, clr_wake_enables, irq;
  rflpc_power_e suspend_mode;
  // Model state: bytes used in receive FIFO, bytes free in transmit FIFO.
  int failures=0, check_count=0, cyc=0, rxm=0, txm=32'h2000, t, l;
  // Short counts keep the run brief; expectations follow these values.
  rflpc_regs #(.WDOG_CYCLES(20), .PHY_RST_CYCLES(4)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .phy_select_pin(phy_select_pin),
    .phy_clk_present_pin(phy_clk_present_pin), .eeprom_load_done(eeprom_load_done),
    .rx_frame_store(rx_frame_store), .rx_frame_len(rx_frame_len), .rx_drain(rx_drain),
    .rx_drain_bytes(rx_drain_bytes), .tx_alloc(tx_alloc), .tx_alloc_bytes(tx_alloc_bytes),
    .tx_release(tx_release), .tx_release_bytes(tx_release_bytes),
    .resume_done(resume_done), .resume_remote(resume_remote),
    .dev_normal_state(dev_normal_state), .hw_config_done(hw_config_done),
    .lite_reset_start(lite_reset_start), .config_entered(config_entered),
    .deconfigured(deconfigured), .device_soft_reset(device_soft_reset),
    .ext_phy_reset(ext_phy_reset), .usb_phy_disconnect(usb_phy_disconnect),
    .eeprom_reload_req(eeprom_reload_req), .clr_wake_status(clr_wake_status),
    .clr_wake_enables(clr_wake_enables), .suspend_mode(suspend_mode), .irq(irq));
  initial forever #4 sys_clk = ~sys_clk;
  // A run still going at cycle 4000 ends as a failure; a hung handshake gives up after 50 cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc==4000) begin failures++; summarize; end
  end
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures==0 && check_count>0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    t=0;
    s_axi_awaddr<=a; s_axi_wdata<=d;
    s_axi_awvalid<=1; s_axi_wvalid<=1; s_axi_bready<=1;
    do begin
      @(posedge sys_clk);
      t++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid<=0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid<=0;
    end while (s_axi_bvalid!==1 && t<50);
    if (s_axi_bvalid!==1) failures++;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  // Read and compare; data is only compared when an OKAY response is expected.
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    t=0;
    s_axi_araddr<=a; s_axi_arvalid<=1; s_axi_rready<=1;
    do begin
      @(posedge sys_clk);
      t++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid<=0;
    end while (s_axi_rvalid!==1 && t<50);
    if (s_axi_rvalid!==1) failures++;
    `CHK("rresp", er, s_axi_rresp)
    if (er==0) `CHK("rdata", e, s_axi_rdata)
  endtask
  initial begin
    void'($urandom(32'hDBF4));
    repeat (2) @(posedge sys_clk);
    reset_n<=1;
    @(posedge sys_clk);
    wr(12'h034, 32'h0, 2'h0);
    // No PHY clocks: ready must wait for the watchdog.
    rc(12'h020, 32'h140, 2'h0);
    rc(12'h018, 32'h0, 2'h0);
    rc(12'h01C, 32'h2000, 2'h0);
    rc(12'h0F0, 32'h0, 2'h2);
    wr(12'h0F0, 32'h1, 2'h2);
    repeat (30) @(posedge sys_clk);
    rc(12'h020, 32'h1C0, 2'h0);
    rc(12'h030, 32'h2, 2'h0);
    `CHK("irq", 1'b0, irq)
    wr(12'h034, 32'h2, 2'h0);
    @(posedge sys_clk);
    `CHK("irq", 1'b1, irq)
    wr(12'h030, 32'h2, 2'h0);
    @(posedge sys_clk);
    `CHK("irq", 1'b0, irq)
    // Back-to-back frames of random length, then one drain and release.
    for (int i=0; i<6; i++) begin
      l=$urandom_range(1, 300);
      rx_frame_len<=l[15:0]; tx_alloc_bytes<=l[15:0];
      rx_frame_store<=1; tx_alloc<=1;
      rxm+=((l+3)/4)*4;
      txm-=l;
      @(posedge sys_clk);
    end
    rx_frame_store<=0; tx_alloc<=0; rx_drain<=1; tx_release<=1;
    @(posedge sys_clk);
    rx_drain<=0; tx_release<=0;
    rxm-=4;
    txm+=8;
    rc(12'h018, rxm, 2'h0);
    rc(12'h01C, txm, 2'h0);
    // Every combination of the two resume bits and the resume origin.
    for (int i=0; i<8; i++) begin
      s=$urandom_range(0, 3);
      wr(12'h020, {22'h0, i[2:1], 1'b0, s, 5'h0}, 2'h0);
      `CHK("suspend", s, suspend_mode)
      resume_remote<=i[0]; resume_done<=1;
      @(posedge sys_clk);
      resume_done<=0;
      @(posedge sys_clk);
      `CHK("clr_sts", i[2], clr_wake_status)
      `CHK("clr_en", i[1] & i[0], clr_wake_enables)
    end
    rc(12'h020, {22'h0, 2'h3, 1'b1, s, 5'h0}, 2'h0);
    // Unconfigured from here: no further suspend selection is written
    deconfigured<=1;
    @(posedge sys_clk);
    deconfigured<=0;
    @(posedge sys_clk);
    `CHK("suspend", POWER_STATE_2, suspend_mode)
    // Soft reset with an external PHY strapped in.
    wr(12'h014, 32'h1, 2'h0);
    @(posedge sys_clk);
    `CHK("soft_rst", 1'b1, device_soft_reset)
    `CHK("phy_rst", 1'b1, ext_phy_reset)
    `CHK("disc", 1'b1, usb_phy_disconnect)
    t=0;
    while (eeprom_reload_req!==1 && t<20) begin
      @(posedge sys_clk);
      t++;
    end
    `CHK("reload", 1'b1, eeprom_reload_req)
    `CHK("disc", 1'b1, usb_phy_disconnect)
    rc(12'h014, 32'h1, 2'h0);
    eeprom_load_done<=1;
    @(posedge sys_clk);
    eeprom_load_done<=0;
    repeat (3) @(posedge sys_clk);
    `CHK("disc", 1'b0, usb_phy_disconnect)
    rc(12'h014, 32'h0, 2'h0);
    rc(12'h018, 32'h0, 2'h0);
    rc(12'h01C, 32'h2000, 2'h0);
    summarize;
  end
endmodule

// *** verilog/rflpc_cfg.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the
 * reset, FIFO level and power control register block.
 * Assumes it is included by its bare name wherever these are needed.
 */
`ifndef RFLPC_CFG_SVH
`define RFLPC_CFG_SVH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define RFLPC_HW_CTL_OFS 12'h014
`define RFLPC_RX_LVL_OFS 12'h018
`define RFLPC_TX_LVL_OFS 12'h01C
`define RFLPC_PMT_OFS 12'h020
`define RFLPC_INT_STS_OFS 12'h030
`define RFLPC_INT_MSK_OFS 12'h034

// ************************************************************
// Field positions.
// ************************************************************
`define RFLPC_SOFTWARE_RESET_TRIGGER_BIT 0
`define RFLPC_RCWS_BIT 9
`define RFLPC_RCWE_BIT 8
`define RFLPC_READY_BIT 7
`define RFLPC_SUSP_LSB 5
`define RFLPC_SUSP_MSB 6
`define RFLPC_INT_SRDONE 0
`define RFLPC_INT_READY 1
`define RFLPC_INT_RESUME 2
`define RFLPC_INT_N 3

// ************************************************************
// Reset values.
// ************************************************************
`define RFLPC_RX_RST 16'h0000
`define RFLPC_TX_RST 16'h2000
`define RFLPC_RCWS_RST 1'b0
`define RFLPC_RCWE_RST 1'b1
`define RFLPC_SUSP_RST 2'h2

// ************************************************************
// Timing: times in ns, counts derived from the clock period.
// ************************************************************
`define RFLPC_CLK_PERIOD_NS 8
`define RFLPC_PHY_RST_NS 1000
`define RFLPC_WDOG_NS 100000
`define RFLPC_PHY_RST_CYC ((`RFLPC_PHY_RST_NS + `RFLPC_CLK_PERIOD_NS - 1) / `RFLPC_CLK_PERIOD_NS)
`define RFLPC_WDOG_CYC ((`RFLPC_WDOG_NS + `RFLPC_CLK_PERIOD_NS - 1) / `RFLPC_CLK_PERIOD_NS)

`endif

// *** verilog/rflpc_pkg.sv ***
/*
 * Types of the reset, FIFO level and power control register block.
 * Assumes nothing of its surroundings.
 */
package rflpc_pkg;
  // Soft reset sequencer states.
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_HOLD = 2'b01,
    SR_LOAD = 2'b10,
    SR_DONE = 2'b11
  } rflpc_sr_state_e;
  // Suspend power state selection.
  typedef enum logic [1:0] {
    POWER_STATE_0 = 2'b00,
    POWER_STATE_1 = 2'b01,
    POWER_STATE_2 = 2'b10,
    POWER_STATE_3 = 2'b11
  } rflpc_power_e;
  // FIFO byte level.
  typedef logic [15:0] rflpc_level_t;
endpackage

// *** verilog/rflpc_regs.sv ***
/*
 * Reset, FIFO level and power control registers behind an AXI4-Lite slave.
 * Assumes device side inputs are on sys_clk, except the PHY select strap
 * and the PHY clock presence pin, which are synchronised here.
 */
// Chosen here: the AXI4-Lite interface to the registers.
// Overview of operation
// - Writing one starts full reset, external PHY too.
// - Soft reset reloads configuration from EEPROM.
// - USB PHY disconnected until reinitialisation ends.
// - Low sixteen bits report receive FIFO bytes used.
// - Each stored frame adds length rounded to word.
// - Transmit level reports free bytes, resets 2000h.
// - Resume clears four frame flags when enabled.
// - Same setting also clears upper wake cause bit.
// - Setting off keeps wake status after resume.
// - Remote wakeup resume clears enables when set.
// - Host initiated resume never clears wake enables.
// - Five named enables excluded from resume clearing.
// - Ready only in normal state after configuration.
// - Without PHY clocks ready waits for watchdog.
// - Two bit field selects suspend power state.
// - Deconfiguration forces suspend selection to 10b.
`timescale 1ns/1ps
`include "rflpc_cfg.svh"

module rflpc_regs #(
  parameter int WDOG_CYCLES = `RFLPC_WDOG_CYC,
  parameter int PHY_RST_CYCLES = `RFLPC_PHY_RST_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phy_select_pin,
  input wire logic phy_clk_present_pin,
  input wire logic eeprom_load_done,
  input wire logic rx_frame_store,
  input wire rflpc_pkg::rflpc_level_t rx_frame_len,
  input wire logic rx_drain,
  input wire rflpc_pkg::rflpc_level_t rx_drain_bytes,
  input wire logic tx_alloc,
  input wire rflpc_pkg::rflpc_level_t tx_alloc_bytes,
  input wire logic tx_release,
  input wire rflpc_pkg::rflpc_level_t tx_release_bytes,
  input wire logic resume_done,
  input wire logic resume_remote,
  input wire logic dev_normal_state,
  input wire logic hw_config_done,
  input wire logic lite_reset_start,
  input wire logic config_entered,
  input wire logic deconfigured,
  output logic device_soft_reset,
  output logic ext_phy_reset,
  output logic usb_phy_disconnect,
  output logic eeprom_reload_req,
  output logic clr_wake_status,
  output logic clr_wake_enables,
  output rflpc_pkg::rflpc_power_e suspend_mode,
  output logic irq
);
  import rflpc_pkg::*;

  // ************************************************************
  // Parameter checks and local widths.
  // ************************************************************
  localparam int WD_W = $clog2(WDOG_CYCLES + 1);
  localparam int PR_W = $clog2(PHY_RST_CYCLES + 1);
  // Counters below cannot serve a zero length.
  if (WDOG_CYCLES < 1 || PHY_RST_CYCLES < 1) begin : g_chk
    $error("rflpc_regs: counts must be at least one");
  end

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  logic [1:0] sel_sync; // Strap synchroniser, stage 0 read only by stage 1.
  logic [1:0] clk_sync; // PHY clock presence synchroniser.
  logic phy_sel; // External PHY in use.
  logic phy_clk_ok; // PHY clocks are running.
  // Two flops per pin; only the second stage is used by logic.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sel_sync <= 2'h0;
      clk_sync <= 2'h0;
    end else begin
      sel_sync <= {sel_sync[0], phy_select_pin};
      clk_sync <= {clk_sync[0], phy_clk_present_pin};
    end
  end
  assign phy_sel = sel_sync[1];
  assign phy_clk_ok = clk_sync[1];

  // ************************************************************
  // AXI4-Lite write channel.
  // ************************************************************
  logic aw_held; // Address taken, waiting for the write.
  logic w_held; // Data taken, waiting for the write.
  logic [11:0] aw_addr; // Held write address.
  logic [31:0] w_data; // Held write data.
  logic [3:0] w_strb; // Held byte strobes.
  logic wr_fire; // The held write is carried out this cycle.
  logic wr_hit; // Held address is mapped.
  logic [11:0] wr_ofs; // Word aligned write address.
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ofs = {aw_addr[11:2], 2'b00};
  assign wr_hit = (wr_ofs == `RFLPC_HW_CTL_OFS) || (wr_ofs == `RFLPC_RX_LVL_OFS) ||
                  (wr_ofs == `RFLPC_TX_LVL_OFS) || (wr_ofs == `RFLPC_PMT_OFS) ||
                  (wr_ofs == `RFLPC_INT_STS_OFS) || (wr_ofs == `RFLPC_INT_MSK_OFS);

  // Address channel; taken in any order relative to the data.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire || !aw_held) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Data channel, mirror of the address channel.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire || !w_held) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Response; an unmapped address answers SLVERR and changes nothing.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register select strobes for the carried out write.
  logic wr_hw;
  logic wr_pmt;
  logic wr_sts;
  logic wr_msk;
  assign wr_hw = wr_fire && (wr_ofs == `RFLPC_HW_CTL_OFS);
  assign wr_pmt = wr_fire && (wr_ofs == `RFLPC_PMT_OFS);
  assign wr_sts = wr_fire && (wr_ofs == `RFLPC_INT_STS_OFS) && w_strb[0];
  assign wr_msk = wr_fire && (wr_ofs == `RFLPC_INT_MSK_OFS) && w_strb[0];

  // ************************************************************
  // Soft reset sequencer.
  // ************************************************************
  rflpc_sr_state_e sr_state; // Sequencer state.
  rflpc_sr_state_e next_sr_state; // Its next value.
  logic sw_reset_bit; // Readable trigger bit.
  logic [PR_W-1:0] hold_cnt; // Reset hold counter.
  logic sr_start; // Software asked for a reset.
  // Writes while a sequence runs are ignored, so one trigger gives one reset.
  assign sr_start = wr_hw && w_strb[0] && w_data[`RFLPC_SOFTWARE_RESET_TRIGGER_BIT] && (sr_state == SR_IDLE);

  // Next state: hold, reload, then release.
  always_comb begin
    next_sr_state = sr_state;
    unique case (sr_state)
      SR_IDLE: begin
        if (sr_start) begin
          next_sr_state = SR_HOLD;
        end
      end
      SR_HOLD: begin
        if (hold_cnt == '0) begin
          next_sr_state = SR_LOAD;
        end
      end
      SR_LOAD: begin
        if (eeprom_load_done) begin
          next_sr_state = SR_DONE;
        end
      end
      SR_DONE: begin
        next_sr_state = SR_IDLE;
      end
    endcase
  end

  // State and hold counter.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sr_state <= SR_IDLE;
      hold_cnt <= '0;
    end else begin
      sr_state <= next_sr_state;
      if (sr_start) begin
        hold_cnt <= PR_W'(PHY_RST_CYCLES - 1);
      end else if (hold_cnt != '0) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
    end
  end

  // Trigger bit stays one for the whole sequence, so software can poll it.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sw_reset_bit <= 1'b0;
    end else if (sr_start) begin
      sw_reset_bit <= 1'b1;
    end else if (sr_state == SR_DONE) begin
      sw_reset_bit <= 1'b0;
    end
  end

  // Sequencer outputs, registered from the next state.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      device_soft_reset <= 1'b0;
      ext_phy_reset <= 1'b0;
      usb_phy_disconnect <= 1'b0;
      eeprom_reload_req <= 1'b0;
    end else begin
      device_soft_reset <= (next_sr_state == SR_HOLD);
      ext_phy_reset <= (next_sr_state == SR_HOLD) && phy_sel;
      // Disconnect spans hold and reload, released only once reload ends.
      usb_phy_disconnect <= (next_sr_state == SR_HOLD) ||
                            (next_sr_state == SR_LOAD);
      eeprom_reload_req <= (sr_state == SR_HOLD) && (next_sr_state == SR_LOAD);
    end
  end
  logic sr_hold; // Device state returns to defaults.
  assign sr_hold = (sr_state == SR_HOLD);

  // ************************************************************
  // FIFO levels.
  // ************************************************************
  rflpc_level_t rx_used; // Receive bytes used.
  rflpc_level_t tx_free; // Transmit bytes free.
  rflpc_level_t rx_len_up; // Frame length rounded up to a word.
  rflpc_level_t rx_add;
  rflpc_level_t rx_sub;
  rflpc_level_t tx_add;
  rflpc_level_t tx_sub;
  assign rx_len_up = (rx_frame_len + 16'h0003) & 16'hFFFC;
  assign rx_add = rx_frame_store ? rx_len_up : 16'h0000;
  assign rx_sub = rx_drain ? rx_drain_bytes : 16'h0000;
  assign tx_add = tx_release ? tx_release_bytes : 16'h0000;
  assign tx_sub = tx_alloc ? tx_alloc_bytes : 16'h0000;

  // Counters; the datapath keeps them in range, no saturation here.
  always_ff @(posedge sys_clk) begin
    if (!reset_n || sr_hold) begin
      rx_used <= `RFLPC_RX_RST;
      tx_free <= `RFLPC_TX_RST;
    end else begin
      rx_used <= rx_used + rx_add - rx_sub;
      tx_free <= tx_free + tx_add - tx_sub;
    end
  end

  // ************************************************************
  // Ready flag and watchdog.
  // ************************************************************
  logic [WD_W-1:0] wdog_cnt; // Watchdog down counter.
  logic wdog_done; // Watchdog has expired.
  logic wdog_arm; // Lite reset, configured entry or soft reset end.
  logic ready; // Readable ready flag.
  logic ready_d; // Ready one cycle ago.
  assign wdog_arm = lite_reset_start || config_entered || (sr_state == SR_DONE);

  // Watchdog restarts on each arm; also armed from reset.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wdog_cnt <= WD_W'(WDOG_CYCLES);
      wdog_done <= 1'b0;
    end else if (wdog_arm) begin
      wdog_cnt <= WD_W'(WDOG_CYCLES);
      wdog_done <= 1'b0;
    end else if (wdog_cnt != '0) begin
      wdog_cnt <= wdog_cnt - 1'b1;
      wdog_done <= (wdog_cnt == WD_W'(1));
    end
  end

  // Ready needs normal state, finished configuration and PHY clocks
  // or an expired watchdog; it drops while a soft reset runs.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ready <= 1'b0;
      ready_d <= 1'b0;
    end else begin
      ready <= dev_normal_state && hw_config_done && (sr_state == SR_IDLE) &&
               (phy_clk_ok || wdog_done);
      ready_d <= ready;
    end
  end

  // ************************************************************
  // Power management control.
  // ************************************************************
  logic rcws; // Resume clears wake status.
  logic rcwe; // Resume clears wake enables.
  // Suspend select and resume options; deconfiguration overrides a write.
  always_ff @(posedge sys_clk) begin
    if (!reset_n || sr_hold) begin
      rcws <= `RFLPC_RCWS_RST;
      rcwe <= `RFLPC_RCWE_RST;
      suspend_mode <= rflpc_power_e'(`RFLPC_SUSP_RST);
    end else begin
      if (wr_pmt && w_strb[1]) begin
        rcws <= w_data[`RFLPC_RCWS_BIT];
        rcwe <= w_data[`RFLPC_RCWE_BIT];
      end
      if (deconfigured) begin
        suspend_mode <= POWER_STATE_2;
      end else if (wr_pmt && w_strb[0]) begin
        // No check of software's choice while unconfigured.
        suspend_mode <= rflpc_power_e'(w_data[`RFLPC_SUSP_MSB:`RFLPC_SUSP_LSB]);
      end
    end
  end

  // Resume clearing pulses to the wake register. The status pulse clears the
  // four frame flags and the upper cause bit; the enable pulse clears only
  // enables outside the five frame and unicast enables.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      clr_wake_status <= 1'b0;
      clr_wake_enables <= 1'b0;
    end else begin
      clr_wake_status <= resume_done && rcws;
      clr_wake_enables <= resume_done && rcwe && resume_remote;
    end
  end

  // ************************************************************
  // Interrupt status and mask.
  // ************************************************************
  logic [`RFLPC_INT_N-1:0] int_evt; // Event pulses.
  logic [`RFLPC_INT_N-1:0] int_sts; // Sticky status.
  logic [`RFLPC_INT_N-1:0] int_msk; // Enable mask.
  assign int_evt[`RFLPC_INT_SRDONE] = (sr_state == SR_DONE);
  assign int_evt[`RFLPC_INT_READY] = ready && !ready_d;
  assign int_evt[`RFLPC_INT_RESUME] = resume_done;

  // Per bit status; an event in the clearing cycle wins so none is lost.
  for (genvar i = 0; i < `RFLPC_INT_N; i++) begin : g_int
    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        int_sts[i] <= 1'b0;
      end else if (int_evt[i]) begin
        int_sts[i] <= 1'b1;
      end else if (wr_sts && w_data[i]) begin
        int_sts[i] <= 1'b0;
      end
    end
  end

  // Mask and interrupt line; the line follows status one cycle later.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      int_msk <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_msk) begin
        int_msk <= w_data[`RFLPC_INT_N-1:0];
      end
      irq <= |(int_sts & int_msk);
    end
  end

  // ************************************************************
  // AXI4-Lite read channel.
  // ************************************************************
  logic [31:0] rd_mux; // Word at the requested address.
  logic rd_hit; // Requested address is mapped.
  // Reserved bits read as zero.
  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'b00})
      `RFLPC_HW_CTL_OFS: rd_mux[`RFLPC_SOFTWARE_RESET_TRIGGER_BIT] = sw_reset_bit;
      `RFLPC_RX_LVL_OFS: rd_mux[15:0] = rx_used;
      `RFLPC_TX_LVL_OFS: rd_mux[15:0] = tx_free;
      `RFLPC_PMT_OFS: begin
        rd_mux[`RFLPC_RCWS_BIT] = rcws;
        rd_mux[`RFLPC_RCWE_BIT] = rcwe;
        rd_mux[`RFLPC_READY_BIT] = ready;
        rd_mux[`RFLPC_SUSP_MSB:`RFLPC_SUSP_LSB] = suspend_mode;
      end
      `RFLPC_INT_STS_OFS: rd_mux[`RFLPC_INT_N-1:0] = int_sts;
      `RFLPC_INT_MSK_OFS: rd_mux[`RFLPC_INT_N-1:0] = int_msk;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time; data registered at address acceptance.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ************************************************************
  // Assertions and covers.
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rflpc_level_t rx_len_up_d; // Rounded length one cycle ago.
  always_ff @(posedge sys_clk) begin
    rx_len_up_d <= rx_len_up;
  end
  logic [15:0] phy_rst_len; // Cycles the external PHY reset has stood so far.
  // Counting the length lets the check follow any PHY_RST_CYCLES value.
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !ext_phy_reset) begin
      phy_rst_len <= 16'h0000;
    end else begin
      phy_rst_len <= phy_rst_len + 16'h0001;
    end
  end

  AST_SR_START: assert property (sr_start |=> device_soft_reset && usb_phy_disconnect)
    else $error("soft reset did not start");
  AST_PHY_RST: assert property ($fell(ext_phy_reset) |-> phy_rst_len == 16'(PHY_RST_CYCLES))
    else $error("external PHY reset too short");
  AST_RELOAD: assert property ((sr_state == SR_HOLD) && (hold_cnt == '0)
    |=> eeprom_reload_req ##1 !eeprom_reload_req)
    else $error("EEPROM reload not requested once");
  AST_DISC: assert property ((sr_state == SR_LOAD) |-> usb_phy_disconnect
    ##[1:2] (usb_phy_disconnect || (sr_state == SR_IDLE)))
    else $error("USB PHY released during reset");
  AST_SELF_CLR: assert property ((sr_state == SR_DONE) |=> !sw_reset_bit
    ##1 !usb_phy_disconnect)
    else $error("soft reset bit did not clear");
  AST_RX_ROUND: assert property (rx_frame_store && !rx_drain && !sr_hold
    |=> rx_used == $past(rx_used) + rx_len_up_d)
    else $error("receive level not word rounded");
  AST_TX_RST: assert property (sr_hold |=> tx_free == `RFLPC_TX_RST)
    else $error("transmit level not at reset value");
  AST_CLR_STS: assert property (resume_done |=> clr_wake_status == $past(rcws))
    else $error("wake status clear wrong");
  AST_CLR_EN: assert property (resume_done && !resume_remote |=> !clr_wake_enables)
    else $error("host resume cleared enables");
  AST_CLR_EN_R: assert property (resume_done && resume_remote && rcwe
    |=> clr_wake_enables ##1 !clr_wake_enables)
    else $error("remote resume did not clear enables");
  AST_READY: assert property (ready |-> $past(dev_normal_state) && $past(hw_config_done))
    else $error("ready without normal state");
  AST_WDOG: assert property (!phy_clk_ok && !wdog_done |=> !ready)
    else $error("ready before watchdog expiry");
  AST_DECONF: assert property (deconfigured && !sr_hold |=> suspend_mode == POWER_STATE_2)
    else $error("deconfigure did not force state");

  COV_SR: cover property ((sr_state == SR_DONE) ##1 (sr_state == SR_IDLE));
  COV_REMOTE: cover property (resume_done && resume_remote && rcwe);
  COV_READY: cover property ($rose(ready));
  COV_IRQ: cover property ($rose(irq));
endmodule
